/* File: logic/pmlp_pkg.sv */
// constants and types shared by the memory lock protection block
package pmlp_pkg;

  // ---------------------------------------------------------------
  // lock byte layout
  // ---------------------------------------------------------------
  localparam int LOCK_W = 8;
  localparam int BOOT_HI_BIT = 5;
  localparam int BOOT_LO_BIT = 4;
  localparam int APP_HI_BIT = 3;
  localparam int APP_LO_BIT = 2;
  localparam int MEM_HI_BIT = 1;
  localparam int MEM_LO_BIT = 0;
  localparam logic [7:0] LOCK_ERASED = 8'hFF;   // every bit unprogrammed
  localparam logic [7:0] LOCK_SAFE = 8'hC0;     // held until the stored byte is loaded
  localparam logic [7:0] UNUSED_MASK = 8'hC0;   // bits that always read one
  localparam logic [7:0] SECT_MASK = 8'h3C;     // boot and application pairs
  localparam logic [7:0] MEM_MASK = 8'h03;      // general memory pair

  // ---------------------------------------------------------------
  // self-programming control
  // ---------------------------------------------------------------
  localparam int SPM_CTRL_W = 5;
  localparam logic [4:0] SPM_CMD_LOCK_SET = 5'h09;  // lock set together with store enable
  localparam logic [2:0] STORE_WIN_CYC = 3'h4;      // store must follow within four cycles
  localparam logic [2:0] READ_WIN_CYC = 3'h3;       // table read must follow within three
  localparam logic [2:0] WIN_IDLE = 3'h0;
  localparam int PC_W = 17;

  // ---------------------------------------------------------------
  // protection modes of a lock pair
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {
    PMLP_MODE1,
    PMLP_MODE2,
    PMLP_MODE3,
    PMLP_MODE4
  } pmlp_mode_t;

  // maps an {upper, lower} pair to its protection mode
  function automatic pmlp_mode_t pmlp_pair_mode(input logic [1:0] pair);
    pmlp_mode_t m;
    m = PMLP_MODE1;
    unique case (pair)
      2'b11: m = PMLP_MODE1;
      2'b10: m = PMLP_MODE2;
      2'b00: m = PMLP_MODE3;
      2'b01: m = PMLP_MODE4;
    endcase
    return m;
  endfunction : pmlp_pair_mode

endpackage : pmlp_pkg

/* File: logic/pmlp_top.sv */
// lock byte storage and protection decode for programming and self-programming
//
// How it works
// - six lock bits, zero means programmed
// - only chip erase returns bits to one
// - byte layout: unused, boot, app, memory pairs
// - memory mode 1 leaves programming unrestricted
// - memory mode 2 stops programming, locks fuses
// - memory mode 3 stops verify, locks boot bits
// - app pair 11 leaves app access free
// - app mode 2 blocks stores into app
// - app mode 3 blocks stores, boot reads
// - app mode 4 blocks reads from boot only
// - app modes 3,4 mask irqs in app when vectors sit in boot
// - boot pair 11 leaves boot access free
// - boot mode 2 blocks stores into boot
// - boot mode 3 blocks stores, app reads
// - boot mode 4 blocks reads from app only
// - boot modes 3,4 mask irqs in boot when vectors sit in app
// - armed store within four cycles sets bits
// - armed table read returns lock or fuses
`timescale 1ns/100ps
`default_nettype none

module pmlp_top
  import pmlp_pkg::*;
(
  input wire logic mclk_i,                       // system clock, 250 MHz
  input wire logic srst_i,                       // synchronous reset, active high
  input wire logic ce_i,                         // clock enable, freezes state when low
  input wire logic [7:0] nv_lock_i,              // stored lock byte from nonvolatile array
  input wire logic [7:0] fuse_i,                 // fuse byte returned by armed table read
  input wire logic chip_erase_i,                 // chip erase command pulse
  input wire logic ext_lock_wr_i,                // programmer writes lock byte, pulse
  input wire logic [7:0] ext_lock_data_i,        // lock byte from programmer
  input wire logic spm_ctrl_wr_i,                // core writes store control bits, pulse
  input wire logic [4:0] spm_ctrl_data_i,        // low five store control bits
  input wire logic store_program_i,              // core executes store instruction, pulse
  input wire logic [7:0] low_working_reg_i,      // low working register value
  input wire logic table_read_i,                 // core executes table read, pulse
  input wire logic ptr_lsb_i,                    // pointer bit 0, fuse when high
  input wire logic [16:0] boot_start_i,          // first word address of boot section
  input wire logic [16:0] pc_i,                  // executing program counter
  input wire logic [16:0] store_addr_i,          // word address targeted by a store
  input wire logic [16:0] read_addr_i,           // word address targeted by a table read
  input wire logic vectors_in_boot_i,            // interrupt vectors sit in boot section
  output logic [7:0] lock_byte_o,                // current lock byte, registered
  output logic lock_loaded_o,                    // stored byte has been loaded
  output logic ext_prog_allow_o,                 // external memory programming allowed
  output logic ext_verify_allow_o,               // external memory verification allowed
  output logic ext_fuse_allow_o,                 // external fuse writes allowed
  output logic ext_boot_lock_allow_o,            // boot lock bits may still change
  output logic store_allow_o,                    // store to store_addr_i allowed
  output logic read_allow_o,                     // table read of read_addr_i allowed
  output logic irq_allow_o,                      // interrupts allowed at pc_i
  output logic special_read_o,                   // table read now returns lock or fuses
  output logic [7:0] read_data_o,                // lock or fuse byte, registered
  output logic read_valid_o                      // read_data_o valid, one-cycle pulse
);

  // ---------------------------------------------------------------
  // section classification
  // ---------------------------------------------------------------
  // true when a word address lies in the boot loader section
  function automatic logic in_boot(input logic [16:0] addr, input logic [16:0] bound);
    return addr >= bound;
  endfunction : in_boot

  logic [7:0] lock_q, lock_d;
  logic loaded_q, loaded_d;
  logic [2:0] win_q, win_d;
  logic [7:0] rdata_q, rdata_d;
  logic rvalid_q, rvalid_d;
  logic pc_boot, store_boot, read_boot;
  pmlp_mode_t mem_mode, app_mode, boot_mode;

  // which section each address falls in
  assign pc_boot = in_boot(pc_i, boot_start_i);
  assign store_boot = in_boot(store_addr_i, boot_start_i);
  assign read_boot = in_boot(read_addr_i, boot_start_i);

  // ---------------------------------------------------------------
  // mode decode
  // ---------------------------------------------------------------
  // modes apply only through programmed bits
  assign mem_mode = pmlp_pair_mode({lock_q[MEM_HI_BIT], lock_q[MEM_LO_BIT]});
  assign app_mode = pmlp_pair_mode({lock_q[APP_HI_BIT], lock_q[APP_LO_BIT]});
  assign boot_mode = pmlp_pair_mode({lock_q[BOOT_HI_BIT], lock_q[BOOT_LO_BIT]});

  // external programming gates; unlisted pair 01 treated as mode 3
  assign ext_prog_allow_o = (mem_mode == PMLP_MODE1);
  assign ext_verify_allow_o = (mem_mode == PMLP_MODE1) || (mem_mode == PMLP_MODE2);
  assign ext_fuse_allow_o = (mem_mode == PMLP_MODE1);
  assign ext_boot_lock_allow_o = ext_verify_allow_o;

  // self-programming store gate per target section
  always_comb begin
    if (store_boot) begin
      store_allow_o = (boot_mode == PMLP_MODE1) || (boot_mode == PMLP_MODE4);
    end else begin
      store_allow_o = (app_mode == PMLP_MODE1) || (app_mode == PMLP_MODE4);
    end
  end

  // table read gate: only cross-section reads are ever blocked
  always_comb begin
    read_allow_o = 1'b1;
    if (!read_boot && pc_boot) begin
      read_allow_o = !((app_mode == PMLP_MODE3) || (app_mode == PMLP_MODE4));
    end else if (read_boot && !pc_boot) begin
      read_allow_o = !((boot_mode == PMLP_MODE3) || (boot_mode == PMLP_MODE4));
    end
  end

  // interrupt mask while running in the section without the vectors
  always_comb begin
    irq_allow_o = 1'b1;
    if (vectors_in_boot_i && !pc_boot) begin
      irq_allow_o = !((app_mode == PMLP_MODE3) || (app_mode == PMLP_MODE4));
    end else if (!vectors_in_boot_i && pc_boot) begin
      irq_allow_o = !((boot_mode == PMLP_MODE3) || (boot_mode == PMLP_MODE4));
    end
  end

  // ---------------------------------------------------------------
  // lock byte and arming window, next state
  // ---------------------------------------------------------------
  // table read sees lock or fuses during the first three window cycles
  assign special_read_o = (win_q > (STORE_WIN_CYC - READ_WIN_CYC));

  always_comb begin
    logic [7:0] prog;
    prog = LOCK_ERASED;
    lock_d = lock_q;
    loaded_d = loaded_q;
    win_d = win_q;
    rdata_d = rdata_q;
    rvalid_d = 1'b0;
    // window counts down and closes by itself
    if (win_q != WIN_IDLE) begin
      win_d = win_q - 3'h1;
    end
    if (spm_ctrl_wr_i && (spm_ctrl_data_i == SPM_CMD_LOCK_SET)) begin
      win_d = STORE_WIN_CYC;
    end
    // programmer write; boot bits frozen once memory mode 3 holds
    if (ext_lock_wr_i) begin
      prog = ext_boot_lock_allow_o ? ext_lock_data_i : (ext_lock_data_i | SECT_MASK);
    end
    // armed store takes section bits from the low working register
    if (store_program_i && (win_q != WIN_IDLE)) begin
      prog = prog & (low_working_reg_i | MEM_MASK);
      win_d = WIN_IDLE;
    end
    // writes only program bits, never erase them
    lock_d = (lock_q & prog) | UNUSED_MASK;
    if (table_read_i && special_read_o) begin
      rdata_d = ptr_lsb_i ? fuse_i : lock_q;
      rvalid_d = 1'b1;
    end
    if (chip_erase_i) begin
      lock_d = LOCK_ERASED;
    end
    // first enabled cycle after reset captures the stored byte
    if (!loaded_q) begin
      lock_d = nv_lock_i | UNUSED_MASK;
      loaded_d = 1'b1;
      win_d = WIN_IDLE;
      rvalid_d = 1'b0;
    end
  end

  // registers; reset holds the most protective byte until loaded
  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      lock_q <= LOCK_SAFE;
      loaded_q <= 1'b0;
      win_q <= WIN_IDLE;
      rdata_q <= LOCK_SAFE;
      rvalid_q <= 1'b0;
    end else if (ce_i) begin
      lock_q <= lock_d;
      loaded_q <= loaded_d;
      win_q <= win_d;
      rdata_q <= rdata_d;
      rvalid_q <= rvalid_d;
    end
  end

  assign lock_byte_o = lock_q;
  assign lock_loaded_o = loaded_q;
  assign read_data_o = rdata_q;
  assign read_valid_o = rvalid_q;

  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (srst_i);

  erase_restores_a: assert property (ce_i && loaded_q && chip_erase_i |=> lock_q == LOCK_ERASED)
    else $error("chip erase did not restore the lock byte");
  never_unprogram_a: assert property (ce_i && loaded_q && !chip_erase_i
    |=> (lock_q | $past(lock_q)) == $past(lock_q))
    else $error("lock bit returned to one without chip erase");
  unused_ones_a: assert property (lock_q[7:6] == 2'b11)
    else $error("unused lock bits not one");
  mem_mode1_a: assert property (lock_q[1:0] == 2'b11 |-> ext_prog_allow_o && ext_fuse_allow_o)
    else $error("mode 1 restricted programming");
  mem_mode2_a: assert property (lock_q[1:0] == 2'b10
    |-> !ext_prog_allow_o && !ext_fuse_allow_o && ext_verify_allow_o)
    else $error("mode 2 gates wrong");
  mem_mode3_a: assert property (lock_q[1:0] == 2'b00 |-> !ext_verify_allow_o && !ext_prog_allow_o)
    else $error("mode 3 allowed verification");
  boot_bits_frozen_a: assert property (ce_i && loaded_q && lock_q[1:0] == 2'b00
    && !chip_erase_i && win_q == WIN_IDLE |=> $stable(lock_q[5:2]))
    else $error("section bits changed in mode 3");
  app_store_block_a: assert property (!store_boot && lock_q[APP_HI_BIT]
    && !lock_q[APP_LO_BIT] |-> !store_allow_o)
    else $error("store into app allowed");
  boot_read_block_a: assert property (read_boot && !pc_boot && !lock_q[BOOT_HI_BIT]
    |-> !read_allow_o)
    else $error("cross read of boot allowed");
  app_irq_mask_a: assert property (vectors_in_boot_i && !pc_boot && !lock_q[APP_HI_BIT]
    |-> !irq_allow_o)
    else $error("irq not masked in app");
  boot_irq_mask_a: assert property (!vectors_in_boot_i && pc_boot && !lock_q[BOOT_HI_BIT]
    |-> !irq_allow_o)
    else $error("irq not masked in boot");
  store_window_a: assert property (ce_i && loaded_q && spm_ctrl_wr_i
    && spm_ctrl_data_i == SPM_CMD_LOCK_SET |=> win_q == STORE_WIN_CYC ##1 (!ce_i || win_q <= 3'h3))
    else $error("arming window wrong");
  idle_stable_a: assert property (ce_i && loaded_q && win_q == WIN_IDLE && !ext_lock_wr_i
    && !chip_erase_i |=> $stable(lock_q))
    else $error("lock byte changed without a write");
  special_read_a: assert property (ce_i && loaded_q && table_read_i && special_read_o
    |=> read_valid_o && read_data_o == ($past(ptr_lsb_i) ? $past(fuse_i) : $past(lock_q)))
    else $error("armed table read returned wrong byte");

  erase_seen_c: cover property (ce_i && loaded_q && chip_erase_i);
  self_set_c: cover property (ce_i && store_program_i && win_q != WIN_IDLE && loaded_q);
  lock_read_c: cover property (read_valid_o && !$past(ptr_lsb_i));
  irq_masked_c: cover property (!irq_allow_o);

endmodule : pmlp_top

`default_nettype wire

/* File: dv/pmlp_core_model.sv */
// core-side model: arms the store control, then issues a store or table read
`timescale 1ns/100ps
`default_nettype none
module pmlp_core_model
  import pmlp_pkg::*;
(
  input wire logic mclk_i,                // system clock
  input wire logic req_i,                 // start one sequence, pulse
  input wire logic rd_kind_i,             // high: table read, low: store
  input wire logic [4:0] ctrl_i,          // control value written at arm
  input wire logic [2:0] gap_i,           // cycles from arm to instruction, nonzero
  output logic spm_ctrl_wr_o,             // control write pulse
  output logic [4:0] spm_ctrl_data_o,     // control data
  output logic store_program_o,           // store instruction pulse
  output logic table_read_o               // table read pulse
);
  logic [2:0] cnt_q = 3'h0;
  logic kind_q = 1'b0;
  initial begin
    spm_ctrl_wr_o = 1'b0;
    spm_ctrl_data_o = 5'h00;
    store_program_o = 1'b0;
    table_read_o = 1'b0;
  end
  // arm first, then the instruction gap cycles later
  always @(posedge mclk_i) begin
    spm_ctrl_wr_o <= req_i;
    store_program_o <= 1'b0;
    table_read_o <= 1'b0;
    // control data is stale outside its write, so it toggles
    spm_ctrl_data_o <= req_i ? ctrl_i : ~spm_ctrl_data_o;
    if (req_i) begin
      cnt_q <= gap_i;
      kind_q <= rd_kind_i;
    end else if (cnt_q != 3'h0) begin
      cnt_q <= cnt_q - 3'h1;
      if (cnt_q == 3'h1) begin
        table_read_o <= kind_q;
        store_program_o <= ~kind_q;
      end
    end
  end
endmodule : pmlp_core_model
`default_nettype wire

/* File: dv/pmlp_top_tb.sv */
// self-checking bench for the lock byte protection block
`timescale 1ns/100ps
`default_nettype none
module pmlp_top_tb;
  import pmlp_pkg::*;
  logic mclk_i = 1'b0, srst_i = 1'b1, ce_i = 1'b1, erase = 1'b0, ewr = 1'b0;
  logic req = 1'b0, kind = 1'b0, lsb = 1'b0, vib = 1'b0, sw, st, rd, rv;
  logic [7:0] nv = 8'hFF, fuse = 8'h00, edat = 8'hFF, r0 = 8'hFF, lk, rdat;
  logic [4:0] ctl = 5'h09, sd;
  logic [2:0] gap = 3'h1;
  logic [16:0] bs = 17'h1F000, pc = 17'h00000, sa = 17'h00000, ra = 17'h00000;
  logic pa, va, fa, ba, sal, ral, ia, ld, spr;
  int n_errors = 0, num_checks = 0, seen, nspr;
  always #2 mclk_i = ~mclk_i;
  pmlp_core_model i_core (.mclk_i(mclk_i), .req_i(req), .rd_kind_i(kind), .ctrl_i(ctl),
    .gap_i(gap), .spm_ctrl_wr_o(sw), .spm_ctrl_data_o(sd), .store_program_o(st),
    .table_read_o(rd));
  pmlp_top i_dut (.mclk_i(mclk_i), .srst_i(srst_i), .ce_i(ce_i), .nv_lock_i(nv),
    .fuse_i(fuse), .chip_erase_i(erase), .ext_lock_wr_i(ewr), .ext_lock_data_i(edat),
    .spm_ctrl_wr_i(sw), .spm_ctrl_data_i(sd), .store_program_i(st),
    .low_working_reg_i(r0), .table_read_i(rd), .ptr_lsb_i(lsb), .boot_start_i(bs),
    .pc_i(pc), .store_addr_i(sa), .read_addr_i(ra), .vectors_in_boot_i(vib),
    .lock_byte_o(lk), .lock_loaded_o(ld), .ext_prog_allow_o(pa), .ext_verify_allow_o(va),
    .ext_fuse_allow_o(fa), .ext_boot_lock_allow_o(ba), .store_allow_o(sal),
    .read_allow_o(ral), .irq_allow_o(ia), .special_read_o(spr), .read_data_o(rdat),
    .read_valid_o(rv));
  // compares one value and counts it
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    num_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic wrap_up();
    $display("checks %0d errors %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : wrap_up
  // erase, then one programmer write
  task automatic set_lock(input logic [7:0] d);
    @(posedge mclk_i) erase <= 1'b1;
    @(posedge mclk_i) begin erase <= 1'b0; ewr <= 1'b1; edat <= d; end
    @(posedge mclk_i) ewr <= 1'b0;
    @(negedge mclk_i);
  endtask : set_lock
  // expected gating: {prog, verify, fuse, bootlock, store, read, irq, 0}
  function automatic logic [7:0] gates(input logic [7:0] l);
    logic m11, m1x, pb, tb, rb;
    m11 = l[1:0] == 2'b11;
    m1x = l[1];
    pb = pc >= bs;
    tb = sa >= bs;
    rb = ra >= bs;
    return {m11, m1x, m11, m1x, tb ? l[4] : l[2],
      (rb == pb) ? 1'b1 : (rb ? l[5] : l[3]),
      (!pb && vib) ? l[3] : ((pb && !vib) ? l[5] : 1'b1), 1'b0};
  endfunction : gates
  // runs one arm sequence and counts read pulses
  task automatic core_seq(input logic k, input logic [4:0] c, input logic [2:0] g);
    @(posedge mclk_i) begin req <= 1'b1; kind <= k; ctl <= c; gap <= g; end
    @(posedge mclk_i) req <= 1'b0;
    seen = 0;
    nspr = 0;
    repeat (8) begin
      @(negedge mclk_i);
      if (rv === 1'b1) seen++;
      if (spr === 1'b1) nspr++;
    end
  endtask : core_seq
  initial begin
    #200000;
    n_errors++;
    wrap_up();
  end
  initial begin
    void'($urandom(33147));
    nv = 8'($urandom());
    repeat (3) @(posedge mclk_i);
    srst_i <= 1'b0;
    repeat (2) @(negedge mclk_i);
    chk(lk, nv | 8'hC0);
    chk({7'h00, ld}, 8'h01);
    // random lock bytes against random addresses
    repeat (150) begin
      set_lock(8'($urandom()));
      chk(lk[7:6], 8'h03);
      @(posedge mclk_i) begin
        bs <= 17'($urandom()); pc <= 17'($urandom()); sa <= 17'($urandom());
        ra <= 17'($urandom()); vib <= 1'($urandom());
      end
      @(negedge mclk_i);
      chk({pa, va, fa, ba, sal, ral, ia, 1'b0}, gates(lk));
    end
    // memory pair programmed to mode 3, then section pairs frozen
    set_lock(8'hFC);
    set_lock(8'hFC);
    @(posedge mclk_i) begin ewr <= 1'b1; edat <= 8'hC3; end
    @(posedge mclk_i) ewr <= 1'b0;
    @(negedge mclk_i) chk(lk, 8'hFC);
    @(posedge mclk_i) erase <= 1'b1;
    @(posedge mclk_i) erase <= 1'b0;
    @(negedge mclk_i) chk(lk, 8'hFF);
    // clock enable low freezes the byte through an erase pulse
    set_lock(8'hF3);
    @(posedge mclk_i) begin ce_i <= 1'b0; erase <= 1'b1; end
    @(posedge mclk_i) erase <= 1'b0;
    @(negedge mclk_i) chk(lk, 8'hF3);
    @(posedge mclk_i) ce_i <= 1'b1;
    // armed store at each gap, one past the window, and a wrong control value
    for (int g = 1; g <= 6; g++) begin
      set_lock(8'hFF);
      @(posedge mclk_i) r0 <= 8'($urandom());
      core_seq(1'b0, (g == 6) ? 5'h01 : 5'h09, (g == 6) ? 3'h1 : 3'(g));
      chk(lk, (g <= 4) ? (8'hC3 | {2'b00, r0[5:2], 2'b00}) : 8'hFF);
    end
    // armed table read at each gap, lock or fuse byte
    for (int g = 1; g <= 4; g++) begin
      set_lock(8'($urandom()) | 8'h03);
      @(posedge mclk_i) begin fuse <= 8'($urandom()); lsb <= 1'($urandom()); end
      core_seq(1'b1, 5'h09, 3'(g));
      chk(8'(seen), (g <= 3) ? 8'h01 : 8'h00);
      chk(8'(nspr), 8'h03);
      if (g <= 3) chk(rdat, lsb ? fuse : lk);
    end
    wrap_up();
  end
endmodule : pmlp_top_tb
`default_nettype wire
